// File: rtl/ssc_defs.vh
`ifndef SSC_DEFS_VH
`define SSC_DEFS_VH

// reserved sector channels
`define SSC_CH_RSV_FIRST  7'd17
`define SSC_CH_A_START    7'd17
`define SSC_CH_A_STOP     7'd18
`define SSC_CH_B_START    7'd19
`define SSC_CH_B_STOP     7'd20
`define SSC_CH_B_STEP     7'd21
`define SSC_CH_A_LOCK0    7'd22
`define SSC_CH_B_LOCK0    7'd26
`define SSC_CH_RSV_LAST   7'd29
`define SSC_CH_COUNT      7'd100
`define SSC_LOCK_SLOTS    3'd4
`define SSC_FETCH_LAST    3'd6

// channel word layout: tuned frequency in 10 Hz units, IF code, threshold code
`define SSC_FREQ_MSB      23
`define SSC_BW_LSB        24
`define SSC_BW_MSB        26
`define SSC_THR_LSB       27
`define SSC_THR_MSB       30

// threshold codes with special meaning
`define SSC_THR_ALWAYS    4'h0
`define SSC_THR_NEVER     4'h9

// register byte offsets
`define SSC_REG_CTRL      12'h000
`define SSC_REG_PARAM     12'h004
`define SSC_REG_STATUS    12'h008
`define SSC_REG_FREQ      12'h00c
`define SSC_MEM_BASE      12'h400
`define SSC_MEM_SPAN      12'h190

// reset values
`define SSC_PARAM_RST     7'h00
`define SSC_FREQ_RST      24'h000000

// dwell per scan step
`define SSC_CLK_MHZ       16'd125
`define SSC_STEP_US       16'd100

`endif

// File: rtl/ssc_chan_mem.v
`timescale 1ns/10ps
`default_nettype none

// channel store: one write port, a bus read port and a scan read port
module ssc_chan_mem #(
    parameter W  = 32,
    parameter D  = 100,
    parameter AW = 7
) (
    input  wire          clk,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [W-1:0]  wdata,
    input  wire [AW-1:0] raddrA,
    input  wire          altSelA,
    input  wire [W-1:0]  altDataA,
    output reg  [W-1:0]  rdataA_r,
    input  wire [AW-1:0] raddrB,
    output reg  [W-1:0]  rdataB_r
);
    reg [W-1:0] mem [0:D-1];    // channel words

    // port a carries the bus read; register data ride the same flop
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdataA_r <= altSelA ? altDataA : mem[raddrA];
        rdataB_r <= mem[raddrB];
    end
endmodule // ssc_chan_mem

`default_nettype wire

// File: rtl/ssc_sector_scan.v
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "ssc_defs.vh"

module ssc_sector_scan #(
    parameter [15:0] STEP_CYCLES = `SSC_STEP_US * `SSC_CLK_MHZ
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [11:0] busAddr,
    input  wire [31:0] busWdata,
    input  wire        busWr,
    input  wire        busRd,
    output wire [31:0] busRdata,
    input  wire        keyDigitStb,
    input  wire [3:0]  keyDigit,
    input  wire        recallKey,
    input  wire        autoScanKey,
    input  wire        lockoutKey,
    input  wire [3:0]  sigLevelCode,
    output reg  [23:0] tunedFreq_r,
    output reg  [2:0]  ifBwCode_r,
    output reg  [3:0]  thrCode_r,
    output reg  [6:0]  channelNumberDisplay_r,
    output reg         lockoutInd_r,
    output reg         scanActive_r,
    output reg         activeSector_r,
    output reg         sigDetect_r
);
    // scan states
    localparam [2:0] S_IDLE  = 3'd0;    // no scan
    localparam [2:0] S_FETCH = 3'd1;    // present sector channel address
    localparam [2:0] S_CAPT  = 3'd2;    // capture sector channel word
    localparam [2:0] S_TUNE  = 3'd3;    // decide on current step
    localparam [2:0] S_DWELL = 3'd4;    // hold tuned step
    localparam [2:0] S_RCLA  = 3'd5;    // present recall address
    localparam [2:0] S_RCLD  = 3'd6;    // load recalled word

    reg  [2:0]  state_r;                // scan state
    reg  [2:0]  fetchIdx_r;             // which sector word is being read
    reg  [23:0] startF_r;               // sector start frequency
    reg  [23:0] stopF_r;                // sector stop frequency
    reg  [23:0] stepB_r;                // sector b step word
    reg  [95:0] lockF_r;                // four lockout frequencies
    reg  [23:0] curF_r;                 // frequency under test
    reg  [15:0] stepCnt_r;              // dwell counter
    reg  [1:0]  lockReq_r;              // operator lockout request per sector
    reg  [1:0]  lock_r;                 // lockout in force per sector
    reg  [6:0]  entry_r;                // keyed channel number
    reg         entryValid_r;           // keypad entry pending
    reg  [1:0]  entryDigits_r;          // digits keyed so far
    reg         lastWasLock_r;          // previous key was lockout
    reg         lastLockSec_r;          // sector hit by that lockout
    reg  [6:0]  rclCh_r;                // channel being recalled

    wire [31:0] memRdB;                 // scan port word
    reg  [6:0]  memAddrB;               // scan port address
    reg  [31:0] regRd;                  // register read value
    reg         regHit;                 // register address decoded
    reg         memHit;                 // memory window decoded
    wire [11:0] memOff = busAddr - `SSC_MEM_BASE;

    // helpers

    // full IF filter bandwidth in 10 Hz units
    function [23:0] bwFreq;
        input [2:0] code;
        begin
            case (code)
                3'd0:    bwFreq = 24'h00001e;   // 300 Hz
                3'd1:    bwFreq = 24'h000064;   // 1 kHz
                3'd2:    bwFreq = 24'h000140;   // 3.2 kHz
                3'd3:    bwFreq = 24'h000258;   // 6 kHz
                3'd4:    bwFreq = 24'h000640;   // 16 kHz
                default: bwFreq = 24'h001388;   // 50 kHz
            endcase
        end
    endfunction

    // true when f lies inside the guard band around a used lockout slot
    function inBand;
        input [23:0] f;
        input [23:0] lk;
        input [23:0] halfW;
        reg   [23:0] d;
        begin
            d      = (f > lk) ? (f - lk) : (lk - f);
            inBand = (lk != 24'h000000) && (d < halfW);
        end
    endfunction

    // channel of the scan data word idx for sector sec
    function [6:0] fetchAddr;
        input       sec;
        input [2:0] idx;
        begin
            if (idx == 3'd0) begin
                fetchAddr = sec ? `SSC_CH_B_START : `SSC_CH_A_START;
            end else if (idx == 3'd1) begin
                fetchAddr = sec ? `SSC_CH_B_STOP : `SSC_CH_A_STOP;
            end else if (idx == 3'd2) begin
                fetchAddr = `SSC_CH_B_STEP;
            end else begin
                fetchAddr = (sec ? `SSC_CH_B_LOCK0 : `SSC_CH_A_LOCK0)
                            + {4'h0, idx - 3'd3};
            end
        end
    endfunction

    // sector of a reserved limit channel, bit 1 flags a match
    function [1:0] limSector;
        input [6:0] ch;
        begin
            if (ch == `SSC_CH_A_START || ch == `SSC_CH_A_STOP) begin
                limSector = 2'b10;
            end else if (ch == `SSC_CH_B_START || ch == `SSC_CH_B_STOP) begin
                limSector = 2'b11;
            end else begin
                limSector = 2'b00;
            end
        end
    endfunction

    // step and guard band
    wire [23:0] halfBw  = bwFreq(ifBwCode_r) >> 1;
    // sector a always uses half bandwidth; b uses its word unless zero
    wire [23:0] stepF   = (activeSector_r && stepB_r != 24'h000000)
                          ? stepB_r : halfBw;
    // 60 dB width taken as twice the nominal width, so half band = bw
    wire [23:0] guardW  = bwFreq(ifBwCode_r);
    wire [24:0] nxtF    = {1'b0, curF_r} + {1'b0, stepF};
    wire        skipHit = inBand(curF_r, lockF_r[23:0], guardW)
                        | inBand(curF_r, lockF_r[47:24], guardW)
                        | inBand(curF_r, lockF_r[71:48], guardW)
                        | inBand(curF_r, lockF_r[95:72], guardW);

    // sector chosen by an autoscan press
    wire [1:0]  keySec  = entryValid_r
                          ? ((entry_r == `SSC_CH_A_START) ? 2'b10 :
                             (entry_r == `SSC_CH_B_START) ? 2'b11 : 2'b00)
                          : limSector(channelNumberDisplay_r);
    wire [1:0]  entSec  = limSector(entry_r);

    // bus decode

    // register and memory window decode, unmapped reads give zero
    always @* begin
        regHit = 1'b1;
        memHit = 1'b0;
        regRd  = 32'h00000000;
        if (busAddr[1:0] != 2'b00) begin
            regHit = 1'b1;                  // misaligned reads as zero
        end else if (busAddr == `SSC_REG_CTRL) begin
            regRd = {30'h00000000, lockReq_r};
        end else if (busAddr == `SSC_REG_PARAM) begin
            regRd = {25'h0000000, thrCode_r, ifBwCode_r};
        end else if (busAddr == `SSC_REG_STATUS) begin
            regRd = {22'h000000, sigDetect_r, lockoutInd_r, lock_r,
                     activeSector_r, scanActive_r, 1'b0, state_r};
        end else if (busAddr == `SSC_REG_FREQ) begin
            regRd = {8'h00, tunedFreq_r};
        end else if (busAddr >= `SSC_MEM_BASE && memOff < `SSC_MEM_SPAN) begin
            regHit = 1'b0;
            memHit = 1'b1;
        end
    end

    // scan port address follows the state
    always @* begin
        if (state_r == S_RCLA) begin
            memAddrB = rclCh_r;
        end else begin
            memAddrB = fetchAddr(activeSector_r, fetchIdx_r);
        end
    end

    // channel store, bus read data leave from its port a flop
    ssc_chan_mem #(
        .W  (32),
        .D  (100),
        .AW (7)
    ) u_mem (
        .clk      (clk),
        .we       (busWr && memHit),
        .waddr    (memOff[8:2]),
        .wdata    (busWdata),
        .raddrA   (memOff[8:2]),
        .altSelA  (regHit || !busRd),
        .altDataA (busRd ? regRd : 32'h00000000),
        .rdataA_r (busRdata),
        .raddrB   (memAddrB),
        .rdataB_r (memRdB)
    );

    // keypad, lockout and scan sequencing in one process, since keys
    // and the scan both steer the state and the lockout flags
    always @(posedge clk) begin
        if (rst) begin
            state_r                <= S_IDLE;
            fetchIdx_r             <= 3'd0;
            startF_r               <= `SSC_FREQ_RST;
            stopF_r                <= `SSC_FREQ_RST;
            stepB_r                <= `SSC_FREQ_RST;
            lockF_r                <= 96'h0;
            curF_r                 <= `SSC_FREQ_RST;
            stepCnt_r              <= 16'h0000;
            lockReq_r              <= 2'b00;
            lock_r                 <= 2'b00;
            entry_r                <= 7'h00;
            entryValid_r           <= 1'b0;
            entryDigits_r          <= 2'd0;
            lastWasLock_r          <= 1'b0;
            lastLockSec_r          <= 1'b0;
            rclCh_r                <= 7'h00;
            tunedFreq_r            <= `SSC_FREQ_RST;
            ifBwCode_r             <= 3'd0;
            thrCode_r              <= 4'h0;
            channelNumberDisplay_r <= 7'h00;
            lockoutInd_r           <= 1'b0;
            scanActive_r           <= 1'b0;
            activeSector_r         <= 1'b0;
            sigDetect_r            <= 1'b0;
        end else begin
            // software writes: lockout requests and manual parameters
            if (busWr && busAddr == `SSC_REG_CTRL) begin
                lockReq_r <= busWdata[1:0];
            end
            if (busWr && busAddr == `SSC_REG_PARAM) begin
                ifBwCode_r <= busWdata[2:0];
                thrCode_r  <= busWdata[6:3];
            end

            // digit entry keeps the first two digits, later ones are dropped
            if (keyDigitStb) begin
                lastWasLock_r <= 1'b0;
                if (!entryValid_r) begin
                    entry_r       <= {3'h0, keyDigit};
                    entryValid_r  <= 1'b1;
                    entryDigits_r <= 2'd1;
                end else if (entryDigits_r == 2'd1) begin
                    entry_r       <= (entry_r << 3) + (entry_r << 1) + {3'h0, keyDigit};
                    entryDigits_r <= 2'd2;
                end
            end

            // lockout key: lock with an entry, return on an immediate repeat
            if (lockoutKey) begin
                if (entryValid_r && entSec[1]) begin
                    lockReq_r[entSec[0]] <= 1'b1;
                    lastWasLock_r        <= 1'b1;
                    lastLockSec_r        <= entSec[0];
                end else if (!entryValid_r && lastWasLock_r) begin
                    lockReq_r[lastLockSec_r] <= 1'b0;
                    lastWasLock_r            <= 1'b0;
                end else begin
                    lastWasLock_r <= 1'b0;
                end
                entryValid_r  <= 1'b0;
                entryDigits_r <= 2'd0;
            end

            // a lockout takes hold at once unless its sector is being swept
            if (!(scanActive_r && activeSector_r == 1'b0)) begin
                lock_r[0] <= lockReq_r[0];
            end
            if (!(scanActive_r && activeSector_r == 1'b1)) begin
                lock_r[1] <= lockReq_r[1];
            end

            // lockout lamp while a locked sector's limit channel is shown
            lockoutInd_r <= limSector(channelNumberDisplay_r) == 2'b10 && lockReq_r[0]
                          || limSector(channelNumberDisplay_r) == 2'b11 && lockReq_r[1];

            // recall key: only while idle, so the scan port is free
            if (recallKey) begin
                lastWasLock_r <= 1'b0;
                entryValid_r  <= 1'b0;
                entryDigits_r <= 2'd0;
                if (entryValid_r && entry_r < `SSC_CH_COUNT && state_r == S_IDLE) begin
                    rclCh_r                <= entry_r;
                    channelNumberDisplay_r <= entry_r;
                    state_r                <= S_RCLA;
                end
            end

            // autoscan key: stops a running scan, otherwise starts one from idle when a sector start channel is keyed
            // or, with no entry pending, a limit channel is shown
            if (autoScanKey) begin
                lastWasLock_r <= 1'b0;
                entryValid_r  <= 1'b0;
                entryDigits_r <= 2'd0;
                if (scanActive_r) begin
                    scanActive_r <= 1'b0;
                    state_r      <= S_IDLE;
                end else if (keySec[1] && state_r == S_IDLE) begin
                    activeSector_r <= keySec[0];
                    scanActive_r   <= 1'b1;
                    fetchIdx_r     <= 3'd0;
                    state_r        <= S_FETCH;
                    if (entryValid_r) begin
                        channelNumberDisplay_r <= entry_r;
                    end
                end
            end else begin
                case (state_r)
                    S_RCLA: begin
                        // address presented, word arrives next cycle
                        state_r <= S_RCLD;
                    end
                    S_RCLD: begin
                        // recalled word sets tuner and parameters
                        tunedFreq_r <= memRdB[`SSC_FREQ_MSB:0];
                        ifBwCode_r  <= memRdB[`SSC_BW_MSB:`SSC_BW_LSB];
                        thrCode_r   <= memRdB[`SSC_THR_MSB:`SSC_THR_LSB];
                        state_r     <= S_IDLE;
                    end
                    S_FETCH: begin
                        state_r <= S_CAPT;
                    end
                    S_CAPT: begin
                        // only the tuned frequency of reserved words is used
                        if (fetchIdx_r == 3'd0) begin
                            startF_r <= memRdB[`SSC_FREQ_MSB:0];
                            curF_r   <= memRdB[`SSC_FREQ_MSB:0];
                        end else if (fetchIdx_r == 3'd1) begin
                            stopF_r <= memRdB[`SSC_FREQ_MSB:0];
                        end else if (fetchIdx_r == 3'd2) begin
                            stepB_r <= memRdB[`SSC_FREQ_MSB:0];
                        end else begin
                            lockF_r[(fetchIdx_r - 3'd3) * 24 +: 24]
                                <= memRdB[`SSC_FREQ_MSB:0];
                        end
                        if (fetchIdx_r == `SSC_FETCH_LAST) begin
                            state_r <= S_TUNE;
                        end else begin
                            fetchIdx_r <= fetchIdx_r + 3'd1;
                            state_r    <= S_FETCH;
                        end
                    end
                    S_TUNE: begin
                        if (curF_r > stopF_r) begin
                            // sector done: pending lockout now applies
                            lock_r[activeSector_r] <= lockReq_r[activeSector_r];
                            fetchIdx_r <= 3'd0;
                            if (!lockReq_r[~activeSector_r]) begin
                                activeSector_r <= ~activeSector_r;
                                state_r        <= S_FETCH;
                            end else if (!lockReq_r[activeSector_r]) begin
                                state_r <= S_FETCH;
                            end else begin
                                scanActive_r <= 1'b0;
                                state_r      <= S_IDLE;
                            end
                        end else if (skipHit) begin
                            // skipped steps cost one cycle each
                            curF_r <= nxtF[24] ? 24'hffffff : nxtF[23:0];
                        end else begin
                            tunedFreq_r <= curF_r;
                            stepCnt_r   <= 16'h0000;
                            state_r     <= S_DWELL;
                        end
                    end
                    S_DWELL: begin
                        // level check each dwell cycle
                        if (thrCode_r == `SSC_THR_ALWAYS) begin
                            sigDetect_r <= 1'b1;
                        end else if (thrCode_r == `SSC_THR_NEVER) begin
                            sigDetect_r <= 1'b0;
                        end else begin
                            sigDetect_r <= sigLevelCode >= thrCode_r;
                        end
                        if (stepCnt_r >= STEP_CYCLES - 16'd1) begin
                            curF_r  <= nxtF[24] ? 24'hffffff : nxtF[23:0];
                            state_r <= S_TUNE;
                        end else begin
                            stepCnt_r <= stepCnt_r + 16'd1;
                        end
                    end
                    default: begin
                        // idle holds; only an unused code is pulled back, so a
                        // recall started by the key branch above is not undone
                        if (state_r != S_IDLE) begin
                            state_r <= S_IDLE;
                        end
                    end
                endcase
            end
        end
    end
endmodule // ssc_sector_scan

`default_nettype wire

// File: verif/ssc_tuner_model.sv
`timescale 1ns/10ps
`default_nettype none
// far-side tuner: one carrier, noise floor elsewhere
module ssc_tuner_model #(parameter [23:0] CARRIER = 24'd200500) (
    input  wire logic [23:0] tunedFreq_r,
    output wire logic [3:0]  sigLevelCode
);
    // strong only on the carrier, so a detect elsewhere is threshold-driven
    assign sigLevelCode = (tunedFreq_r == CARRIER) ? 4'h7 : 4'h1;
endmodule // ssc_tuner_model
`default_nettype wire

// File: verif/ssc_sector_scan_chk_props.sv
`timescale 1ns/10ps
`default_nettype none
module ssc_sector_scan_chk #(parameter [15:0] STEP_CYCLES = 16'd4) (
    input wire logic clk, rst, busRd, keyDigitStb, recallKey, autoScanKey, lockoutKey,
    input wire logic [3:0] keyDigit, thrCode_r,
    input wire logic [31:0] busRdata,
    input wire logic [6:0] channelNumberDisplay_r,
    input wire logic lockoutInd_r, scanActive_r, activeSector_r, sigDetect_r
);
    reg  [1:0] nDig_r;  // digits in the pending entry
    reg  [6:0] ent_r;   // pending channel number
    // shadow keypad entry; later digits are dropped like the design does
    always @(posedge clk) begin
        if (rst | recallKey | autoScanKey | lockoutKey) begin
            nDig_r <= 2'd0;
        end else if (keyDigitStb && nDig_r != 2'd2) begin
            nDig_r <= nDig_r + 2'd1;
            ent_r  <= (nDig_r == 2'd0) ? 7'(keyDigit) : ent_r * 7'd10 + 7'(keyDigit);
        end
    end
    wire entIdle = nDig_r == 2'd2 && !scanActive_r;  // full entry, no scan
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_stop_scan: assert property (autoScanKey && scanActive_r |=> !scanActive_r)
        else $error("scan kept running");
    a_recall_show: assert property (recallKey && entIdle |=> channelNumberDisplay_r == $past(ent_r))
        else $error("recall display wrong");
    a_keyed_start: assert property (autoScanKey && entIdle && (ent_r == 7'd17 || ent_r == 7'd19)
        |=> scanActive_r && activeSector_r == $past(ent_r[1]) && channelNumberDisplay_r == $past(ent_r))
        else $error("keyed start wrong");
    a_bare_start: assert property (autoScanKey && !scanActive_r && nDig_r == 2'd0
        && channelNumberDisplay_r inside {[7'd17:7'd20]}
        && !$past(recallKey) && !$past(recallKey, 2)
        |=> scanActive_r && activeSector_r == ($past(channelNumberDisplay_r) > 7'd18))
        else $error("bare start wrong");
    a_lock_lamp: assert property ($stable(channelNumberDisplay_r)
        && !(channelNumberDisplay_r inside {[7'd17:7'd20]}) |-> !lockoutInd_r)
        else $error("lockout lamp lit off sector");
    a_never_det: assert property (thrCode_r == 4'h9 && !sigDetect_r |=> !sigDetect_r)
        else $error("detect with code nine");
    a_always_det: assert property (scanActive_r && thrCode_r == 4'h0
        |-> ##[0:40] (sigDetect_r || !scanActive_r))
        else $error("no detect with code zero");
    a_read_idle: assert property (!busRd |=> busRdata == 32'h0)
        else $error("read data without read");
    cover property (autoScanKey && scanActive_r);
    cover property (scanActive_r && activeSector_r);
    cover property (lockoutInd_r && scanActive_r);
endmodule // ssc_sector_scan_chk
bind ssc_sector_scan ssc_sector_scan_chk #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.clk, .rst, .busRd,
    .keyDigitStb, .recallKey, .autoScanKey, .lockoutKey, .keyDigit, .thrCode_r, .busRdata,
    .channelNumberDisplay_r, .lockoutInd_r, .scanActive_r, .activeSector_r, .sigDetect_r);
`default_nettype wire

// File: verif/two_sector_frequency_scan_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module two_sector_frequency_scan_control_bench;
    logic clk = 0, rst = 1, busWr = 0, busRd = 0, keyDigitStb = 0;
    logic recallKey = 0, autoScanKey = 0, lockoutKey = 0;
    logic [11:0] busAddr = 0;
    logic [31:0] busWdata = 0;
    logic [3:0]  keyDigit = 0;
    wire  [3:0]  sigLevelCode, thrCode_r;
    wire  [31:0] busRdata;
    wire  [23:0] tunedFreq_r;
    wire  [2:0]  ifBwCode_r;
    wire  [6:0]  channelNumberDisplay_r;
    wire         lockoutInd_r, scanActive_r, activeSector_r, sigDetect_r;
    integer      miscompares = 0, check_count = 0, i;
    logic [38:0] rows [0:5];  // channel number, channel word
    always #4 clk = ~clk;
    // short dwell keeps the scan walks brief
    ssc_sector_scan #(.STEP_CYCLES(16'd16)) u_dut (.clk, .rst, .busAddr, .busWdata, .busWr,
        .busRd, .busRdata, .keyDigitStb, .keyDigit, .recallKey, .autoScanKey, .lockoutKey,
        .sigLevelCode, .tunedFreq_r, .ifBwCode_r, .thrCode_r, .channelNumberDisplay_r,
        .lockoutInd_r, .scanActive_r, .activeSector_r, .sigDetect_r);
    ssc_tuner_model u_tuner (.tunedFreq_r, .sigLevelCode);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk) {busWr, busAddr, busWdata} <= {1'b1, a, d};
        @(posedge clk) busWr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk) {busRd, busAddr} <= {1'b1, a};
        @(posedge clk) busRd <= 1'b0;
        @(negedge clk) chk(busRdata, e);
    endtask
    // 0..9 digit, 10 recall, 11 autoscan, 12 lockout
    task key(input logic [3:0] k);
        @(posedge clk) {keyDigitStb, recallKey, autoScanKey, lockoutKey} <= {k < 10, k == 10, k == 11, k == 12};
        keyDigit <= k;
        @(posedge clk) {keyDigitStb, recallKey, autoScanKey, lockoutKey} <= 4'h0;
    endtask
    task ent(input logic [6:0] c);
        key(4'(c / 10));
        key(4'(c % 10));
    endtask
    // next tuned step, or the first time a given frequency shows
    task nf(input logic [23:0] e, input bit eq);
        integer n;
        logic [23:0] o;
        o = tunedFreq_r;
        for (n = 0; n < 400 && (eq ? tunedFreq_r !== e : tunedFreq_r === o); n++) @(negedge clk);
        chk(tunedFreq_r, e);
    endtask
    task print_verdict;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog well beyond the expected run of under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict;
    end
    initial begin
        rows = '{{7'd17, 8'h03, 24'd100000}, {7'd18, 8'h03, 24'd100900}, {7'd19, 8'h03, 24'd200000},
            {7'd20, 8'h03, 24'd201000}, {7'd21, 8'h03, 24'd500}, {7'd45, 8'h03, 24'd5000}};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk) chk({scanActive_r, channelNumberDisplay_r, tunedFreq_r}, 0);
        for (i = 22; i < 30; i++) wr(12'(12'h400 + 4 * i), 0);
        for (i = 0; i < 6; i++) begin
            wr(12'(12'h400 + 4 * rows[i][38:32]), rows[i][31:0]);
            rd(12'(12'h400 + 4 * rows[i][38:32]), rows[i][31:0]);
        end
        rd(12'h590, 0);
        ent(45);
        key(10);
        repeat (3) @(negedge clk);
        chk(channelNumberDisplay_r, 45);
        chk({thrCode_r, ifBwCode_r, tunedFreq_r}, 31'h3001388);
        ent(19);
        key(12);
        repeat (2) @(negedge clk) chk(lockoutInd_r, 0);
        rd(12'h000, 2);
        ent(20);
        key(10);
        repeat (3) @(negedge clk);
        chk(lockoutInd_r, 1);
        ent(17);
        key(11);
        nf(100000, 0);
        chk(channelNumberDisplay_r, 17);
        for (i = 1; i < 4; i++) nf(24'(100000 + 300 * i), 0);
        nf(100000, 0);
        ent(19);
        key(12);
        key(12);
        nf(100900, 1);
        nf(200000, 0);
        nf(200500, 0);
        ent(19);
        key(12);
        nf(201000, 0);
        nf(100000, 0);
        key(11);
        @(negedge clk) chk(scanActive_r, 0);
        key(11);
        @(negedge clk) chk({scanActive_r, activeSector_r}, 2'b10);
        nf(100300, 0);
        chk(sigDetect_r, 1);
        wr(12'h004, 32'h0000004b);
        nf(100600, 0);
        chk(sigDetect_r, 0);
        wr(12'h004, 32'h0000000b);
        rd(12'h004, 32'h0000000b);
        nf(100900, 0);
        chk(sigDetect_r, 1);
        print_verdict;
    end
endmodule // two_sector_frequency_scan_control_bench
`default_nettype wire
